// ### hw/pwo_pkg.sv
// Purpose: Shared constants and types for the pressure window/offset/status slice
// Assumes: Classic Wishbone, 32-bit data, byte offsets are index times four
// Notes: Register data sits in the low 8 bits of each word
package pwo_pkg;
    localparam logic [7:0] IDX_HI_THR_L = 8'h46; // High threshold low byte
    localparam logic [7:0] IDX_HI_THR_H = 8'h47; // High threshold high byte
    localparam logic [7:0] IDX_LO_THR_L = 8'h48; // Low threshold low byte
    localparam logic [7:0] IDX_LO_THR_H = 8'h49; // Low threshold high byte
    localparam logic [7:0] IDX_TRIM_L = 8'h4c; // Offset trim low byte
    localparam logic [7:0] IDX_TRIM_H = 8'h4d; // Offset trim high byte
    localparam logic [7:0] IDX_STATUS = 8'h60; // Signal path status
    localparam logic [7:0] IDX_CTRL = 8'h70; // Lock, sense, stretch select, selftest
    localparam logic [7:0] IDX_RESULT_L = 8'h71; // Corrected result low byte
    localparam logic [7:0] IDX_RESULT_H = 8'h72; // Corrected result high byte
    localparam logic [7:0] IDX_ERR = 8'h73; // Parity error flag
    localparam logic [7:0] IDX_IRQ_STAT = 8'h74; // Sticky event status
    localparam logic [7:0] IDX_IRQ_EN = 8'h75; // Event enable
    localparam logic [7:0] IDX_IRQ_CLR = 8'h76; // Write-one-to-clear
    localparam logic [7:0] STATUS_RESET = 8'h08; // Only never-run set
    localparam int STAT_NEVER_RUN = 3;
    localparam int STAT_RUNNING = 2;
    localparam int STAT_CM_FAULT = 1;
    localparam int STAT_ST_FAULT = 0;
    localparam int CTRL_LOCK = 7;
    localparam int CTRL_SENSE = 6;
    localparam int CTRL_PS_LSB = 4;
    localparam int PATH_INIT_CYCLES = 16; // Path reinit length, cycles
    localparam int EV_WINDOW = 0;
    localparam int EV_CM = 1;
    localparam int EV_ST = 2;
    localparam int EV_PARITY = 3;

    // Control register layout
    typedef struct packed {
        logic lock;
        logic sense;
        logic [1:0] stretch;
        logic [3:0] selftest;
    } pwo_ctrl_t;

    // Sample carrier from the calibration path
    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } pwo_sample_t;
endpackage

// ### hw/pwo_regs.sv
// Function
// R1 - Threshold and trim writes only before lock
// R2 - Parity guards threshold and trim storage
// R3 - Two unsigned 16-bit thresholds, byte split
// R4 - Zero threshold skips only that comparison
// R5 - Both zero keeps interrupt off
// R6 - Thresholds form window comparator on pressure
// R7 - Signed trim added to calibrated pressure
// R8 - Changing trim resets processing path
// R9 - Host waits for path init before reads
// R10 - Host picks trim avoiding range damage
// R11 - Never-run set by reset, cleared by selftest; here selftest bit 1 alone leaves it set
// R12 - Running equals OR of selftest bits
// R13 - Common-mode fault sticky, cleared by read
// R14 - Selftest fault cleared only by reset
// R15 - Read-only status layout, reset 08h
// R16 - Sense bit picks outside or inside window
// R17 - Zero stretch: pin follows last sample
// R18 - Each new sample compared once
//
// Purpose: Register slice with window comparator, offset trim and status
// Assumes: Calibrated samples and fault events arrive on clock_i
// Notes: Nonzero stretch modes behave as zero stretch here
//        Ack one cycle after request
//        Lock clears only on reset
//        Events arrive on clock_i
//        Trim change restarts path
//        Set wins over every clear
`timescale 1ns/100ps
module pwo_regs #(
    parameter int INIT_CYCLES = pwo_pkg::PATH_INIT_CYCLES
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire pwo_pkg::pwo_sample_t cal_sample_i,
    input wire logic cm_limit_exceeded_i,
    input wire logic selftest_failed_i,
    input wire logic status_sent_i,
    output logic [15:0] sensor_result_o,
    output logic result_valid_o,
    output logic path_reset_o,
    output logic pressure_irq_o,
    output logic [3:0] selftest_control_o,
    output logic irq_o
);
    // Countdown is 16 bits wide
    // Zero would hold path reset forever
    if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_init_range
        $error("INIT_CYCLES out of range");
    end

    // One check bit per stored byte
    // Mismatch shows on the next clock
    // Checked every cycle, not on read
    // Cheap: a single XOR tree each
    // Even parity over a byte plus its check bit
    function automatic logic par9(input logic [7:0] b);
        par9 = ^b;
    endfunction

    // Register state
    // Each output below is one flop
    // Bytes kept split, as on the bus
    logic [7:0] hi_l_q, hi_h_q, lo_l_q, lo_h_q, tr_l_q, tr_h_q; // Stored bytes
    logic [5:0] par_q; // One parity bit per protected byte
    pwo_pkg::pwo_ctrl_t ctrl_q; // Control fields
    logic never_run_q, cm_fault_q, st_fault_q; // Status flags
    logic [15:0] result_q; // Offset-corrected result
    logic valid_q; // Result valid strobe
    logic win_q; // Pin level
    logic [15:0] init_cnt_q; // Path reinit countdown
    logic path_rst_q; // Path held in reset
    logic err_q; // Parity mismatch seen
    logic [3:0] ev_stat_q, ev_en_q; // Interrupt status and enable
    logic irq_q; // Interrupt level
    logic ack_q; // Bus answer
    logic [31:0] rdat_q; // Bus read data
    logic win_prev_q; // For window event edge

    // Bus decode: single cycle answer, byte lane 0 carries data
    // The ack cycle is masked by ack_q
    // so a held stb is not taken twice
    // Lane 0 carries register data
    // Upper lanes ignored on writes
    // Index is byte address over four
    // Write lands on the taking edge
    // Ack follows one cycle later
    logic req, wr, rd, wr0, locked;
    logic [7:0] idx;
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign wr0 = wr && wb_sel_i[0];
    assign idx = wb_adr_i[9:2];
    assign locked = ctrl_q.lock;

    // Protected writes pass only while open
    // Lock gates the strobe itself
    // Locked writes are still acked
    // but leave storage untouched
    logic open_wr;
    assign open_wr = wr0 && !locked; // R1

    // Threshold and trim storage with parity
    // Check bit written with its byte
    // so the pair stays consistent
    // Thresholds: plain unsigned bytes
    // Trim kept raw, sign used in adder
    // Locked writes never reach here
    // Unmapped indices fall through
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            hi_l_q <= 8'h00;
            hi_h_q <= 8'h00;
            lo_l_q <= 8'h00;
            lo_h_q <= 8'h00;
            tr_l_q <= 8'h00;
            tr_h_q <= 8'h00;
            par_q <= 6'h00;
        end else if (open_wr) begin // R1
            unique case (idx)
                pwo_pkg::IDX_HI_THR_L: begin
                    hi_l_q <= wb_dat_i[7:0]; // R3
                    par_q[0] <= par9(wb_dat_i[7:0]); // R2
                end
                pwo_pkg::IDX_HI_THR_H: begin
                    hi_h_q <= wb_dat_i[7:0]; // R3
                    par_q[1] <= par9(wb_dat_i[7:0]); // R2
                end
                pwo_pkg::IDX_LO_THR_L: begin
                    lo_l_q <= wb_dat_i[7:0]; // R3
                    par_q[2] <= par9(wb_dat_i[7:0]); // R2
                end
                pwo_pkg::IDX_LO_THR_H: begin
                    lo_h_q <= wb_dat_i[7:0]; // R3
                    par_q[3] <= par9(wb_dat_i[7:0]); // R2
                end
                pwo_pkg::IDX_TRIM_L: begin
                    tr_l_q <= wb_dat_i[7:0];
                    par_q[4] <= par9(wb_dat_i[7:0]); // R2
                end
                pwo_pkg::IDX_TRIM_H: begin
                    tr_h_q <= wb_dat_i[7:0];
                    par_q[5] <= par9(wb_dat_i[7:0]); // R2
                end
                default: begin
                end
            endcase
        end
    end

    // Parity check runs every cycle; a mismatch is sticky until reset
    // Software cannot clear the flag
    // Suspect storage needs a reset
    // A bad byte is still used as is
    // The flag only reports it
    // Flag also raises event bit 3
    logic par_bad;
    assign par_bad = (par9(hi_l_q) != par_q[0]) || (par9(hi_h_q) != par_q[1]) ||
                     (par9(lo_l_q) != par_q[2]) || (par9(lo_h_q) != par_q[3]) ||
                     (par9(tr_l_q) != par_q[4]) || (par9(tr_h_q) != par_q[5]);
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            err_q <= 1'b0;
        end else if (par_bad) begin
            err_q <= 1'b1; // R2
        end
    end

    // Control register; lock is one-way, cleared only by reset
    // Lock ORs in, never back to zero
    // Sense and stretch lock too
    // Selftest stays writable
    // so tests run after lock
    // Limitation: stretch is stored
    // but does not time the pin
    // Selftest bits leave on a port
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q <= '0;
        end else if (wr0 && idx == pwo_pkg::IDX_CTRL) begin
            ctrl_q.lock <= ctrl_q.lock | wb_dat_i[pwo_pkg::CTRL_LOCK];
            ctrl_q.selftest <= wb_dat_i[3:0];
            if (!locked) begin // R1
                ctrl_q.sense <= wb_dat_i[pwo_pkg::CTRL_SENSE];
                ctrl_q.stretch <= wb_dat_i[pwo_pkg::CTRL_PS_LSB +: 2];
            end
        end
    end

    // Trim change restarts the path; only a changed value counts
    // Same value again: no restart
    // so a setup refresh loses nothing
    // Countdown holds path reset
    // for INIT_CYCLES clocks
    // Last count drops path reset
    // Locked writes never restart it
    logic trim_chg;
    assign trim_chg = open_wr && ((idx == pwo_pkg::IDX_TRIM_L && wb_dat_i[7:0] != tr_l_q) ||
                                  (idx == pwo_pkg::IDX_TRIM_H && wb_dat_i[7:0] != tr_h_q));
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            init_cnt_q <= 16'h0000;
            path_rst_q <= 1'b0;
        end else if (trim_chg) begin
            init_cnt_q <= 16'(INIT_CYCLES); // R8
            path_rst_q <= 1'b1; // R8
        end else if (init_cnt_q != 16'h0000) begin
            init_cnt_q <= init_cnt_q - 16'h0001;
            path_rst_q <= (init_cnt_q != 16'h0001);
        end
    end

    // Offset-corrected result; samples are dropped during reinit
    // Trim is two's complement
    // 16-bit add wraps for both signs
    // Nothing saturates: the host
    // must keep the trim off the rails
    // Sample in trim-change cycle dropped
    // so no result mixes two trims
    // Valid pulses once per kept sample
    logic [15:0] sum;
    assign sum = cal_sample_i.value + {tr_h_q, tr_l_q}; // R7
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            result_q <= 16'h0000;
            valid_q <= 1'b0;
        end else begin
            valid_q <= cal_sample_i.valid && !path_rst_q && !trim_chg;
            if (cal_sample_i.valid && !path_rst_q && !trim_chg) begin
                result_q <= sum; // R7
            end
        end
    end

    // Window comparison on each fresh result
    // Zero limit turns its side off
    // A limit equal to the result
    // counts as inside
    logic [15:0] hi_thr, lo_thr;
    logic hi_on, lo_on, above, below, outside, cond;
    assign hi_thr = {hi_h_q, hi_l_q};
    assign lo_thr = {lo_h_q, lo_l_q};
    assign hi_on = hi_thr != 16'h0000; // R4
    assign lo_on = lo_thr != 16'h0000; // R4
    assign above = hi_on && (result_q > hi_thr); // R6
    assign below = lo_on && (result_q < lo_thr); // R6
    assign outside = above || below;
    // Inside needs every enabled limit satisfied
    // With one side off, inside means
    // the good side of the other limit
    assign cond = (hi_on || lo_on) && (ctrl_q.sense ? !outside : outside); // R5 R16
    // Both off forces the pin low at once
    // and is checked first, so a stale
    // sample cannot raise it again
    // Other limit writes act on the
    // next sample
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            win_q <= 1'b0;
        end else if (!hi_on && !lo_on) begin
            win_q <= 1'b0; // R5
        end else if (valid_q) begin
            win_q <= cond; // R17 R18
        end
    end

    // Status flags; set wins over the read clear
    // Never-run only falls
    // Selftest bit 1 is not a run
    // Event beats a read in one cycle
    // so no fault is lost
    // Selftest fault has no clear path
    logic stat_rd;
    assign stat_rd = rd && idx == pwo_pkg::IDX_STATUS;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            never_run_q <= 1'b1; // R11
            cm_fault_q <= 1'b0;
            st_fault_q <= 1'b0;
        end else begin
            if (ctrl_q.selftest[3] || ctrl_q.selftest[2] || ctrl_q.selftest[0]) begin
                never_run_q <= 1'b0; // R11
            end
            if (cm_limit_exceeded_i) begin
                cm_fault_q <= 1'b1; // R13
            end else if (stat_rd || status_sent_i) begin
                cm_fault_q <= 1'b0; // R13
            end
            if (selftest_failed_i) begin
                st_fault_q <= 1'b1; // R14
            end
        end
    end

    // Bits 7 to 4 read as zero
    // Running is live from control
    logic [7:0] status;
    assign status = {4'h0, never_run_q, |ctrl_q.selftest, cm_fault_q, st_fault_q}; // R12 R15

    // Interrupt events: window rise, faults, parity
    // Sticky bit per source
    // A new event beats a clear
    // The irq output lags a cycle
    // Bit 0: condition turns true
    // Bit 3: parity mismatch
    // Enable only masks the output
    // Status still collects when off
    logic [3:0] ev;
    assign ev = {par_bad, selftest_failed_i, cm_limit_exceeded_i, cond && valid_q && !win_prev_q};
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ev_stat_q <= 4'h0;
            ev_en_q <= 4'h0;
            win_prev_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            win_prev_q <= win_q;
            if (wr0 && idx == pwo_pkg::IDX_IRQ_EN) begin
                ev_en_q <= wb_dat_i[3:0];
            end
            if (wr0 && idx == pwo_pkg::IDX_IRQ_CLR) begin
                ev_stat_q <= (ev_stat_q & ~wb_dat_i[3:0]) | ev;
            end else begin
                ev_stat_q <= ev_stat_q | ev;
            end
            irq_q <= |(ev_stat_q & ev_en_q);
        end
    end

    // Bus answer, one cycle after the request; unmapped reads zero
    // Read data zero outside ack
    // so a stray look reads zero
    // Clear register reads as zero
    // Unmapped writes are dropped
    // Status read also clears the
    // common-mode fault
    // Read data is from before clear
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            rdat_q <= 32'h0000_0000;
            if (rd) begin
                unique case (idx)
                    pwo_pkg::IDX_HI_THR_L: rdat_q[7:0] <= hi_l_q;
                    pwo_pkg::IDX_HI_THR_H: rdat_q[7:0] <= hi_h_q;
                    pwo_pkg::IDX_LO_THR_L: rdat_q[7:0] <= lo_l_q;
                    pwo_pkg::IDX_LO_THR_H: rdat_q[7:0] <= lo_h_q;
                    pwo_pkg::IDX_TRIM_L: rdat_q[7:0] <= tr_l_q;
                    pwo_pkg::IDX_TRIM_H: rdat_q[7:0] <= tr_h_q;
                    pwo_pkg::IDX_STATUS: rdat_q[7:0] <= status; // R15
                    pwo_pkg::IDX_CTRL: rdat_q[7:0] <= ctrl_q;
                    pwo_pkg::IDX_RESULT_L: rdat_q[7:0] <= result_q[7:0];
                    pwo_pkg::IDX_RESULT_H: rdat_q[7:0] <= result_q[15:8];
                    pwo_pkg::IDX_ERR: rdat_q[7:0] <= {7'h00, err_q};
                    pwo_pkg::IDX_IRQ_STAT: rdat_q[7:0] <= {4'h0, ev_stat_q};
                    pwo_pkg::IDX_IRQ_EN: rdat_q[7:0] <= {4'h0, ev_en_q};
                    default: rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Outputs straight from flops
    // No logic on any output path
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign sensor_result_o = result_q;
    assign result_valid_o = valid_q;
    assign path_reset_o = path_rst_q;
    assign pressure_irq_o = win_q;
    assign selftest_control_o = ctrl_q.selftest;
    assign irq_o = irq_q;
endmodule // pwo_regs

// ### verif/pwo_regs_assertions.sv
// Purpose: Port-level properties of the pressure window/offset/status slice
// Assumes: One clock domain, reset_i asynchronous and active high
// Notes: Bus timing follows the single-cycle ack of the slice
`timescale 1ns/100ps
module pwo_regs_assertions #(
    parameter int INIT_CYCLES = 16
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire pwo_pkg::pwo_sample_t cal_sample_i,
    input wire logic cm_limit_exceeded_i,
    input wire logic selftest_failed_i,
    input wire logic status_sent_i,
    input wire logic [15:0] sensor_result_o,
    input wire logic result_valid_o,
    input wire logic path_reset_o,
    input wire logic pressure_irq_o,
    input wire logic [3:0] selftest_control_o,
    input wire logic irq_o
);
    localparam int PR_MAX = INIT_CYCLES + 8; // Loose ceiling, exact length is the designer's
    logic rd_stat; // Status read on the bus
    logic wr_trim; // Write aimed at either trim byte
    assign rd_stat = wb_cyc_i && wb_stb_i && !wb_we_i && (wb_adr_i[9:2] == 8'h60);
    assign wr_trim = wb_cyc_i && wb_stb_i && wb_we_i &&
        (wb_adr_i[9:2] == 8'h4c || wb_adr_i[9:2] == 8'h4d);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // Every taken request is answered on the next edge
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_stat_reserved; wb_ack_o && $past(rd_stat) |-> wb_dat_o[31:4] == 28'h0; endproperty
    a_stat_reserved: assert property (p_stat_reserved) else $error("status high bits set");
    property p_stat_running;
        wb_ack_o && $past(rd_stat) && ($past(selftest_control_o, 2) == selftest_control_o)
        |-> wb_dat_o[2] == (|selftest_control_o);
    endproperty
    a_stat_running: assert property (p_stat_running) else $error("running flag wrong");
    property p_valid_cause; result_valid_o |-> $past(cal_sample_i.valid); endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("result without sample");
    // The pin moves on a fresh sample, or falls when a write zeroes both limits
    property p_pin_cause;
        $changed(pressure_irq_o) |-> $past(result_valid_o) ||
            ($fell(pressure_irq_o) && $past(wb_cyc_i, 2) && $past(wb_we_i, 2));
    endproperty
    a_pin_cause: assert property (p_pin_cause) else $error("pin moved without sample");
    property p_path_cause; $rose(path_reset_o) |-> $past(wr_trim) || $past(wr_trim, 2); endproperty
    a_path_cause: assert property (p_path_cause) else $error("path reset without trim write");
    property p_path_bound; $rose(path_reset_o) |-> ##[1:PR_MAX] !path_reset_o; endproperty
    a_path_bound: assert property (p_path_bound) else $error("path reset never ends");
endmodule // pwo_regs_assertions

bind pwo_regs pwo_regs_assertions #(.INIT_CYCLES(INIT_CYCLES)) u_pwo_chk (
    .clock_i(clock_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cal_sample_i(cal_sample_i),
    .cm_limit_exceeded_i(cm_limit_exceeded_i), .selftest_failed_i(selftest_failed_i),
    .status_sent_i(status_sent_i), .sensor_result_o(sensor_result_o),
    .result_valid_o(result_valid_o), .path_reset_o(path_reset_o),
    .pressure_irq_o(pressure_irq_o), .selftest_control_o(selftest_control_o), .irq_o(irq_o));

// ### verif/test_pwo_regs.sv
// Purpose: Self-checking bench for the pressure window/offset/status slice
// Assumes: Short path reinit (INIT_CYCLES = 2)
// Notes: Lock test runs last, the lock holds until reset
`timescale 1ns/100ps
module test_pwo_regs;
    logic clock_i, reset_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o; // Clock, reset, bus strobes
    logic [9:0] wb_adr_i; // Byte address
    logic [3:0] wb_sel_i; // Byte lanes
    logic [31:0] wb_dat_i, wb_dat_o, rd; // Bus data and last read
    pwo_pkg::pwo_sample_t cal_sample_i; // Calibrated sample stream
    logic cm_limit_exceeded_i, selftest_failed_i, status_sent_i; // Fault events
    logic [15:0] sensor_result_o; // Corrected result
    logic result_valid_o, path_reset_o, pressure_irq_o, irq_o; // Status outputs
    logic [3:0] selftest_control_o; // Selftest bits
    int n_mismatch, samples_checked; // Counters
    pwo_regs #(.INIT_CYCLES(2)) DUT (.clock_i(clock_i), .reset_i(reset_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cal_sample_i(cal_sample_i), .cm_limit_exceeded_i(cm_limit_exceeded_i),
        .selftest_failed_i(selftest_failed_i), .status_sent_i(status_sent_i),
        .sensor_result_o(sensor_result_o), .result_valid_o(result_valid_o),
        .path_reset_o(path_reset_o), .pressure_irq_o(pressure_irq_o),
        .selftest_control_o(selftest_control_o), .irq_o(irq_o));
    // 40 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic cycle; waits on ack under a bound, never on a fixed count
    task bus(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clock_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, wd};
        do begin
            @(posedge clock_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) n_mismatch++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task wr16(input logic [7:0] idx, input logic [15:0] v);
        bus(1'b1, idx, v[7:0]);
        bus(1'b1, idx + 8'h01, v[15:8]);
    endtask
    // One sample pulse, then wait until the pin has settled
    task smp(input logic [15:0] v);
        @(posedge clock_i);
        cal_sample_i <= '{valid: 1'b1, value: v};
        @(posedge clock_i);
        cal_sample_i.valid <= 1'b0;
        #1 chk({31'h0, result_valid_o}, 32'h1);
        repeat (3) @(posedge clock_i);
        #1;
    endtask
    task win(input logic [7:0] ctrl, input logic [15:0] hi, lo, s, input logic pin);
        bus(1'b1, pwo_pkg::IDX_CTRL, ctrl);
        wr16(pwo_pkg::IDX_HI_THR_L, hi);
        wr16(pwo_pkg::IDX_LO_THR_L, lo);
        smp(s);
        chk({31'h0, pressure_irq_o}, {31'h0, pin});
        chk({16'h0, sensor_result_o}, {16'h0, s});
    endtask
    // Trim write, then wait out any path reinit
    task trimwr(input logic [7:0] idx, input logic [7:0] v, input logic busy);
        int n;
        n = 0;
        bus(1'b1, idx, v);
        #1;
        chk({31'h0, path_reset_o}, {31'h0, busy});
        while (path_reset_o !== 1'b0 && n < 40) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 40) n_mismatch++;
    endtask
    // Bit 0 common-mode, bit 1 status sent a cycle later, bit 2 selftest failure
    task ev(input logic [2:0] e);
        @(posedge clock_i);
        cm_limit_exceeded_i <= e[0];
        selftest_failed_i <= e[2];
        @(posedge clock_i);
        cm_limit_exceeded_i <= 1'b0;
        selftest_failed_i <= 1'b0;
        status_sent_i <= e[1];
        @(posedge clock_i);
        status_sent_i <= 1'b0;
        repeat (2) @(posedge clock_i);
    endtask
    task st_step(input logic [7:0] ctrl, input logic [2:0] e, input logic [7:0] exp);
        bus(1'b1, pwo_pkg::IDX_CTRL, ctrl);
        ev(e);
        bus(1'b0, pwo_pkg::IDX_STATUS, 8'h00);
        chk(rd, {24'h0, exp});
        chk({28'h0, selftest_control_o}, {28'h0, ctrl[3:0]});
    endtask
    task t_reset;
        for (int i = 8'h46; i <= 8'h4d; i++) begin
            bus(1'b0, 8'(i), 8'h00);
            chk(rd, 32'h0);
        end
        bus(1'b0, pwo_pkg::IDX_STATUS, 8'h00);
        chk(rd, {24'h0, pwo_pkg::STATUS_RESET});
        bus(1'b0, pwo_pkg::IDX_ERR, 8'h00);
        chk(rd, 32'h0);
        bus(1'b0, 8'h50, 8'h00);
        chk(rd, 32'h0);
    endtask
    task t_irq;
        bus(1'b1, pwo_pkg::IDX_IRQ_CLR, 8'h0f);
        bus(1'b1, pwo_pkg::IDX_IRQ_EN, 8'h02);
        ev(3'b001);
        chk({31'h0, irq_o}, 32'h1);
        bus(1'b1, pwo_pkg::IDX_IRQ_CLR, 8'h02);
        repeat (2) @(posedge clock_i);
        #1 chk({31'h0, irq_o}, 32'h0);
        bus(1'b1, pwo_pkg::IDX_IRQ_EN, 8'h00);
        ev(3'b001);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b0, pwo_pkg::IDX_IRQ_STAT, 8'h00);
        chk(rd, 32'h2);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #(25 * 20000);
        n_mismatch++;
        finish_test;
    end
    // Main sequence
    initial begin
        reset_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, cm_limit_exceeded_i} = 4'h0;
        {selftest_failed_i, status_sent_i} = 2'b00;
        {wb_adr_i, wb_dat_i, cal_sample_i} = '0;
        wb_sel_i = 4'h1;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (6) @(posedge clock_i);
        reset_i <= 1'b0;
        t_reset;
        win(8'h00, 16'h1234, 16'h0100, 16'h2000, 1'b1);
        bus(1'b0, pwo_pkg::IDX_HI_THR_H, 8'h00);
        chk(rd, 32'h12);
        win(8'h00, 16'h1234, 16'h0100, 16'h0800, 1'b0);
        win(8'h00, 16'h1234, 16'h0100, 16'h0080, 1'b1);
        win(8'h40, 16'h1234, 16'h0100, 16'h0800, 1'b1);
        win(8'h40, 16'h1234, 16'h0100, 16'h2000, 1'b0);
        win(8'h00, 16'h1234, 16'h0000, 16'h0080, 1'b0);
        win(8'h00, 16'h1234, 16'h0000, 16'h2000, 1'b1);
        win(8'h00, 16'h0000, 16'h0100, 16'h0080, 1'b1);
        win(8'h00, 16'h0000, 16'h0100, 16'h2000, 1'b0);
        win(8'h00, 16'h0000, 16'h0000, 16'h2000, 1'b0);
        trimwr(pwo_pkg::IDX_TRIM_L, 8'hf0, 1'b1);
        trimwr(pwo_pkg::IDX_TRIM_H, 8'hff, 1'b1);
        smp(16'h0100);
        chk({16'h0, sensor_result_o}, 32'h00f0);
        st_step(8'h00, 3'b001, 8'h0a);
        st_step(8'h00, 3'b000, 8'h08);
        st_step(8'h00, 3'b011, 8'h08);
        st_step(8'h02, 3'b000, 8'h0c);
        st_step(8'h01, 3'b000, 8'h04);
        st_step(8'h00, 3'b100, 8'h01);
        st_step(8'h00, 3'b000, 8'h01);
        t_irq;
        bus(1'b1, pwo_pkg::IDX_CTRL, 8'h80);
        bus(1'b1, pwo_pkg::IDX_HI_THR_L, 8'haa);
        bus(1'b0, pwo_pkg::IDX_HI_THR_L, 8'h00);
        chk(rd, 32'h0);
        trimwr(pwo_pkg::IDX_TRIM_L, 8'h11, 1'b0);
        bus(1'b0, pwo_pkg::IDX_TRIM_L, 8'h00);
        chk(rd, 32'hf0);
        finish_test;
    end
endmodule // test_pwo_regs
